// ---- rtl/oms_core.sv ----
// Purpose: execution datapath for increment-skip, OR, move, store, load and no-operation
// Assumes: instruction words come from logic on CLK_IN, so no synchroniser
// Notes: file registers are held locally; the datapath reads them combinationally, the observation port through a register
`timescale 1ns/1ps
`default_nettype none
module oms_core
#(
   parameter int FILE_DEPTH = oms_pkg::FILE_DEPTH
)
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // instruction stream
   input wire logic INSTR_VALID_IN,
   input wire logic [oms_pkg::INSTR_W-1:0] INSTR_IN,
   // file register observation
   input wire logic [oms_pkg::ADDR_W-1:0] FILE_RD_ADDR_IN,
   output logic [oms_pkg::DATA_W-1:0] FILE_RD_DATA_OUT,
   // architectural state
   output logic [oms_pkg::DATA_W-1:0] ACC_OUT,
   output logic ZERO_OUT,
   output logic SQUASH_NEXT_OUT,
   output logic RETIRED_OUT
);
   import oms_pkg::*;

   // ***************************************
   // decode
   // ***************************************
   logic [DATA_W-1:0] file_mem [FILE_DEPTH];
   logic [DATA_W-1:0] acc_reg;
   logic zero_reg;
   logic retired_reg;
   logic [DATA_W-1:0] rd_data_reg;
   oms_state_t state_reg;
   oms_state_t state_next;

   wire logic [OPC_W-1:0] opcode = INSTR_IN[INSTR_W-1:OPC_LSB];
   wire logic dest = INSTR_IN[DEST_BIT];
   wire logic [ADDR_W-1:0] faddr = INSTR_IN[ADDR_W-1:0];
   wire logic [DATA_W-1:0] literal = INSTR_IN[DATA_W-1:0];
   wire logic running = (state_reg == OMS_RUN);
   wire logic exec = INSTR_VALID_IN && running;
   wire logic squash = INSTR_VALID_IN && !running;
   wire logic is_nop = (opcode == OPC_NOP);
   wire logic is_store = (opcode == OPC_STORE);
   wire logic is_or_reg = (opcode == OPC_OR_REG);
   wire logic is_move = (opcode == OPC_MOVE);
   wire logic is_inc = (opcode == OPC_INC_SKIP);
   // full-width compare: don't-care operand bits arrive as zeros
   wire logic is_load = (opcode == OPC_LOAD_LIT);
   wire logic is_or_lit = (opcode == OPC_OR_LIT);

   // ***************************************
   // datapath
   // ***************************************
   wire logic [DATA_W-1:0] file_val = file_mem[faddr];
   wire logic [DATA_W-1:0] inc_sum = file_val + DATA_ONE;
   wire logic inc_null = (inc_sum == DATA_ZERO);
   wire logic [DATA_W-1:0] or_reg_val = acc_reg | file_val;
   wire logic [DATA_W-1:0] or_lit_val = acc_reg | literal;
   wire logic [DATA_W-1:0] reg_result = is_inc ? inc_sum : (is_or_reg ? or_reg_val : file_val);
   wire logic reg_op = is_inc || is_or_reg || is_move;
   wire logic acc_from_reg = exec && reg_op && (dest == DEST_ACC);
   wire logic file_we = exec && ((reg_op && (dest == DEST_FILE)) || is_store);
   wire logic [DATA_W-1:0] file_wdata = is_store ? acc_reg : reg_result;
   wire logic acc_we = acc_from_reg || (exec && (is_load || is_or_lit));
   wire logic [DATA_W-1:0] acc_wdata = acc_from_reg ? reg_result : (is_load ? literal : or_lit_val);
   // inc, store, load and nop leave the flag alone
   wire logic zero_we = exec && (is_or_reg || is_or_lit || is_move);
   wire logic [DATA_W-1:0] zero_src = is_or_lit ? or_lit_val : reg_result;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         OMS_RUN:
         begin
            if (exec && is_inc && inc_null)
            begin
               state_next = OMS_SQUASH;
            end
         end
         OMS_SQUASH:
         begin
            if (INSTR_VALID_IN)
            begin
               state_next = OMS_RUN; // squashed word retires as a no-operation
            end
         end
         default:
         begin
            state_next = OMS_RUN;
         end
      endcase
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         state_reg <= OMS_RUN;
         acc_reg <= DATA_ZERO;
         zero_reg <= 1'b0;
         retired_reg <= 1'b0;
         rd_data_reg <= DATA_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         retired_reg <= INSTR_VALID_IN;
         rd_data_reg <= file_mem[FILE_RD_ADDR_IN];
         if (acc_we)
         begin
            acc_reg <= acc_wdata;
         end
         if (zero_we)
         begin
            zero_reg <= (zero_src == DATA_ZERO);
         end
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         for (int i = 0; i < FILE_DEPTH; i++)
         begin
            file_mem[i] <= DATA_ZERO;
         end
      end
      else if (file_we)
      begin
         file_mem[faddr] <= file_wdata;
      end
   end

   assign ACC_OUT = acc_reg;
   assign ZERO_OUT = zero_reg;
   assign SQUASH_NEXT_OUT = !running;
   assign RETIRED_OUT = retired_reg;
   assign FILE_RD_DATA_OUT = rd_data_reg;

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   // ***************************************
   // sequences
   // ***************************************
   sequence s_inc_null;
      exec && is_inc && inc_null;
   endsequence
   sequence s_squash_armed;
      !running;
   endsequence
   sequence s_squash_done;
      squash ##1 (running && $stable(acc_reg) && $stable(zero_reg));
   endsequence
   sequence s_zero_tracks_acc;
      zero_reg == (acc_reg == DATA_ZERO);
   endsequence

   // ***************************************
   // properties
   // ***************************************
   chk_inc_to_acc: assert property (exec && is_inc && !dest |=> acc_reg == $past(inc_sum))
      else $error("increment result not in accumulator");
   chk_inc_to_file: assert property (exec && is_inc && dest |=> file_mem[$past(faddr)] == $past(inc_sum))
      else $error("increment result not in file register");
   chk_inc_acc_keep: assert property (exec && is_inc && dest |=> $stable(acc_reg))
      else $error("increment to file changed accumulator");
   chk_skip_squash: assert property (s_inc_null |=> s_squash_armed)
      else $error("zero increment did not arm the squash");
   chk_squash_hold: assert property (!running && !INSTR_VALID_IN |=> !running)
      else $error("pending squash lost during a gap");
   // the discarded word must change nothing, yet still retire
   chk_squash_end: assert property (squash |-> s_squash_done)
      else $error("squashed word changed state");
   chk_squash_quiet: assert property (squash |-> !file_we && !acc_we && !zero_we)
      else $error("squashed word enabled a write");
   chk_squash_retire: assert property (squash |=> RETIRED_OUT)
      else $error("squashed word did not retire");
   chk_no_skip: assert property (exec && is_inc && !inc_null |=> running && $stable(zero_reg))
      else $error("nonzero increment skipped or touched flag");
   chk_inc_flag_keep: assert property (exec && is_inc |=> $stable(zero_reg))
      else $error("increment touched the zero flag");
   chk_or_literal: assert property (exec && is_or_lit |=>
      acc_reg == $past(or_lit_val) ##0 s_zero_tracks_acc)
      else $error("or literal wrong");
   chk_or_register: assert property (exec && is_or_reg && !dest |=>
      acc_reg == $past(or_reg_val) ##0 s_zero_tracks_acc)
      else $error("or register wrong");
   chk_or_reg_file: assert property (exec && is_or_reg && dest |=>
      file_mem[$past(faddr)] == $past(or_reg_val) && $stable(acc_reg))
      else $error("or register to file wrong");
   chk_or_file_zero: assert property (exec && is_or_reg && dest |=>
      zero_reg == ($past(or_reg_val) == DATA_ZERO))
      else $error("or register to file did not set zero flag");
   chk_move_zero: assert property (exec && is_move |=> zero_reg == ($past(file_val) == 0))
      else $error("move did not update zero flag");
   chk_move_acc: assert property (exec && is_move && !dest |=> acc_reg == $past(file_val))
      else $error("move did not load accumulator");
   chk_move_file: assert property (exec && is_move && dest |=>
      file_mem[$past(faddr)] == $past(file_val) && $stable(acc_reg))
      else $error("move to file changed register or accumulator");
   chk_store_file: assert property (exec && is_store |=>
      file_mem[$past(faddr)] == $past(acc_reg) && $stable(zero_reg))
      else $error("store accumulator wrong");
   chk_store_acc_keep: assert property (exec && is_store |=> $stable(acc_reg))
      else $error("store changed accumulator");
   chk_load_lit: assert property (exec && is_load |=> acc_reg == $past(literal) && $stable(zero_reg))
      else $error("load literal wrong");
   chk_nop_quiet: assert property ((exec && is_nop) || squash |=> $stable(acc_reg) && $stable(zero_reg))
      else $error("no-operation changed state");
   chk_nop_retire: assert property (exec && is_nop |=> RETIRED_OUT && running)
      else $error("no-operation took more than one cycle");
endmodule : oms_core
`default_nettype wire

// ---- rtl/oms_pkg.sv ----
// Purpose: constants for the OR / move / increment-skip execution datapath
// Assumes: one 14-bit instruction word per cycle, opcode in the top six bits
// Notes: opcode values are local encodings of this core
package oms_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int INSTR_W = 14;
   localparam int OPC_W = 6;
   // instruction fields
   localparam int OPC_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int FILE_DEPTH = 128;
   // opcodes
   localparam logic [OPC_W-1:0] OPC_NOP = 6'h00;
   localparam logic [OPC_W-1:0] OPC_STORE = 6'h01;
   localparam logic [OPC_W-1:0] OPC_OR_REG = 6'h04;
   localparam logic [OPC_W-1:0] OPC_MOVE = 6'h08;
   localparam logic [OPC_W-1:0] OPC_INC_SKIP = 6'h0F;
   localparam logic [OPC_W-1:0] OPC_LOAD_LIT = 6'h30;
   localparam logic [OPC_W-1:0] OPC_OR_LIT = 6'h38;
   // destination select values
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   typedef enum logic [1:0]
   {
      OMS_RUN = 2'b01,
      OMS_SQUASH = 2'b10
   } oms_state_t;
endpackage : oms_pkg

// ---- sim/oms_core_tb.sv ----
// Purpose: self-checking bench for the OR / move / increment-skip datapath
// Assumes: inputs change on the falling edge; outputs are sampled on the falling edge
// Notes: expected values follow the instruction rules, not the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module oms_core_tb;
   import oms_pkg::*;
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0;
   logic [INSTR_W-1:0] ins = 14'h0000;
   logic [ADDR_W-1:0] rda = 7'h00;
   logic [DATA_W-1:0] rdd, acc;
   logic zf, sq, ret;
   int miscompares = 0, comparisons = 0;
   always #5 clk = ~clk;
   oms_core uut (.CLK_IN(clk), .RST_IN(rst), .INSTR_VALID_IN(vld), .INSTR_IN(ins),
      .FILE_RD_ADDR_IN(rda), .FILE_RD_DATA_OUT(rdd), .ACC_OUT(acc), .ZERO_OUT(zf),
      .SQUASH_NEXT_OUT(sq), .RETIRED_OUT(ret));
   // ****************
   // drive helpers
   // ****************
   function automatic logic [INSTR_W-1:0] fw(logic [OPC_W-1:0] o, logic d, logic [ADDR_W-1:0] f);
      return {o, d, f};
   endfunction : fw
   task automatic send(logic [INSTR_W-1:0] w);
      vld = 1'b1; ins = w; @(posedge clk); @(negedge clk);
   endtask : send
   task automatic idle();
      vld = 1'b0; @(posedge clk); @(negedge clk);
   endtask : idle
   task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      rda = a; idle(); `CHK(rdd, e)
   endtask : rd
   task automatic az(logic [DATA_W-1:0] a, logic z);
      `CHK(acc, a) `CHK(zf, z)
   endtask : az
   // ****************
   // scenarios
   // ****************
   task automatic t_lit();
      send({OPC_LOAD_LIT, 8'h00}); az(8'h00, 1'b0);
      send({OPC_OR_LIT, 8'h00}); az(8'h00, 1'b1);
      send({OPC_LOAD_LIT, 8'h5A}); az(8'h5A, 1'b1);
      send({OPC_OR_LIT, 8'hA5}); az(8'hFF, 1'b0);
      `CHK(ret, 1'b1)
      idle(); `CHK(ret, 1'b0)
   endtask : t_lit
   task automatic t_move();
      send(fw(OPC_STORE, 1'b0, 7'h05)); az(8'hFF, 1'b0);
      rd(7'h05, 8'hFF);
      send({OPC_LOAD_LIT, 8'h00}); send(fw(OPC_MOVE, 1'b1, 7'h05)); az(8'h00, 1'b0);
      rd(7'h05, 8'hFF);
      send(fw(OPC_MOVE, 1'b1, 7'h07)); az(8'h00, 1'b1);
      send(fw(OPC_MOVE, 1'b0, 7'h05)); az(8'hFF, 1'b0);
   endtask : t_move
   task automatic t_orreg();
      send({OPC_LOAD_LIT, 8'h0F}); send(fw(OPC_STORE, 1'b0, 7'h08));
      send({OPC_LOAD_LIT, 8'hF0}); send(fw(OPC_OR_REG, 1'b1, 7'h08)); az(8'hF0, 1'b0);
      rd(7'h08, 8'hFF);
      send({OPC_LOAD_LIT, 8'h00}); send(fw(OPC_OR_REG, 1'b0, 7'h07)); az(8'h00, 1'b1);
      send(fw(OPC_OR_REG, 1'b0, 7'h08)); az(8'hFF, 1'b0);
   endtask : t_orreg
   task automatic t_skip();
      send({OPC_LOAD_LIT, 8'hFE}); send(fw(OPC_STORE, 1'b0, 7'h09));
      send(fw(OPC_INC_SKIP, 1'b1, 7'h09)); `CHK(sq, 1'b0)
      send(fw(OPC_INC_SKIP, 1'b1, 7'h09)); `CHK(sq, 1'b1)
      send({OPC_LOAD_LIT, 8'h33}); az(8'hFE, 1'b0);
      `CHK(sq, 1'b0)
      `CHK(ret, 1'b1)
      rd(7'h09, 8'h00);
      send(fw(OPC_INC_SKIP, 1'b0, 7'h09)); az(8'h01, 1'b0);
      `CHK(sq, 1'b0)
      send(fw(OPC_INC_SKIP, 1'b0, 7'h08)); az(8'h00, 1'b0);
      `CHK(sq, 1'b1)
      idle(); send({OPC_LOAD_LIT, 8'h44}); az(8'h00, 1'b0);
      send({OPC_LOAD_LIT, 8'h44}); az(8'h44, 1'b0);
      rd(7'h08, 8'hFF);
   endtask : t_skip
   task automatic t_nop();
      send(fw(OPC_NOP, 1'b0, 7'h08)); az(8'h44, 1'b0);
      `CHK(ret, 1'b1)
      idle(); `CHK(ret, 1'b0)
      rd(7'h08, 8'hFF);
   endtask : t_nop
   // ****************
   // run control
   // ****************
   task automatic final_report();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   initial
   begin
      #20000;
      miscompares++;
      final_report();
   end
   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      az(8'h00, 1'b0);
      `CHK(sq, 1'b0)
      t_lit();
      t_move();
      t_orreg();
      t_skip();
      t_nop();
      final_report();
   end
endmodule : oms_core_tb
`default_nettype wire
